// ==== common/hps_pkg.sv ====
package hps_pkg;
  // register byte offsets
  localparam logic [7:0] HPS_OFS_SHIFT = 8'h00;
  localparam logic [7:0] HPS_OFS_CTRL = 8'h04;
  localparam logic [7:0] HPS_OFS_STAT = 8'h08;
  localparam logic [7:0] HPS_OFS_HOME = 8'h0c;
  localparam logic [7:0] HPS_OFS_POS = 8'h10;
  // control fields
  localparam int HPS_CTRL_SPD = 0;
  localparam int HPS_CTRL_COND = 1;
  localparam int HPS_CTRL_START = 2;
  localparam int HPS_CTRL_ERRCLR = 3;
  localparam int HPS_CTRL_MTH_LSB = 4;
  localparam int HPS_CTRL_MTH_W = 3;
  // status fields
  localparam int HPS_ST_BUSY = 0;
  localparam int HPS_ST_DONE = 1;
  localparam int HPS_ST_LIMERR = 2;
  localparam int HPS_ST_ZPASS = 3;
  localparam int HPS_ST_NOZERO = 4;
  localparam int HPS_ST_COND_ACT = 5;
  localparam int HPS_ST_FWD_ERR = 6;
  localparam int HPS_ST_REV_ERR = 7;
  // reset values
  localparam logic [31:0] HPS_SHIFT_RST = 32'h0000_0000;
  localparam logic HPS_SPD_RST = 1'b0;
  localparam logic HPS_COND_RST = 1'b0;
  // return methods
  typedef enum logic [2:0] {
    HPS_M_DOG = 3'h0,
    HPS_M_COUNT = 3'h1,
    HPS_M_DATASET = 3'h2,
    HPS_M_CRADLE = 3'h3,
    HPS_M_STOPPER = 3'h4,
    HPS_M_LIMSW = 3'h5
  } hps_method_t;
  typedef enum logic [1:0] {
    HPS_IDLE = 2'b00,
    HPS_SEEK = 2'b01,
    HPS_SHIFT = 2'b11,
    HPS_FIN = 2'b10
  } hps_state_t;
endpackage

// ==== rtl/hps_pos_cnt.sv ====
`timescale 1ns/10ps
// tracks position from step pulses, latches zero point
module hps_pos_cnt #(
  parameter int W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic step_i,
  input wire logic dir_up_i,
  input wire logic latch_i,
  output logic [W-1:0] pos_o,
  output logic [W-1:0] latched_o
);
  logic [W-1:0] pos_q;
  logic [W-1:0] lat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_q <= '0;
    end else if (step_i) begin
      pos_q <= dir_up_i ? pos_q + W'(1) : pos_q - W'(1);
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_q <= '0;
    end else if (latch_i) begin
      lat_q <= pos_q;
    end
  end
  assign pos_o = pos_q;
  assign latched_o = lat_q;
endmodule

// ==== rtl/hps_zpass.sv ====
`timescale 1ns/10ps
// zero-pass flag with home-set condition
module hps_zpass (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cond_cfg_i,
  input wire logic amp_power_i,
  input wire logic ref_pass_i,
  output logic cond_act_o,
  output logic zero_pass_flag_o
);
  logic cond_q;
  logic pwr_q;
  logic zp_q;
  logic arm_q;
  logic pwr_rise;
  assign pwr_rise = amp_power_i & ~pwr_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= amp_power_i;
    end
  end
  // armed only by a system reset; condition sampled at next power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arm_q <= 1'b1;
    end else if (pwr_rise) begin
      arm_q <= 1'b0; // see R11
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cond_q <= 1'b0;
    end else if (pwr_rise && arm_q) begin
      cond_q <= cond_cfg_i; // see R11
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zp_q <= 1'b0;
    end else if (!amp_power_i) begin
      zp_q <= 1'b0;
    end else if (pwr_rise && arm_q && cond_cfg_i) begin
      zp_q <= 1'b1; // see R10
    end else if (pwr_rise && !arm_q && cond_q) begin
      zp_q <= 1'b1; // see R10
    end else if (ref_pass_i) begin
      zp_q <= 1'b1; // see R8
    end
  end
  assign cond_act_o = cond_q;
  assign zero_pass_flag_o = zp_q;
endmodule

// ==== rtl/hps_axis.sv ====
`timescale 1ns/10ps
//
// Contract
// R1: signed 32-bit shift distance, default zero
// R2: shift speed select, 0 return, 1 creep
// R3: after zero point, travel shift, set home
// R4: limit hit during shift raises major error
// R5: shift only for dog/count/cradle/limit methods
// R6: monitor and status update after shift ends
// R7: configurer keeps distances within 32-bit range
// R8: home return needs zero-pass flag set
// R9: home-set condition defaults to pass required
// R10: condition 1 sets zero-pass at power-on
// R11: condition change needs reset then power cycle
// R12: avoid no-pass condition for endless axes
// R13: shift sign sets motion direction
module hps_axis (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic zero_point_i,
  input wire logic ref_pass_i,
  input wire logic amp_power_i,
  input wire logic forward_limit_switch_i,
  input wire logic reverse_limit_switch_i,
  input wire logic step_done_i,
  output logic move_o,
  output logic dir_up_o,
  output logic creep_o,
  output logic home_done_o,
  output logic major_err_o,
  output logic zero_pass_flag_o
);
  logic [31:0] shift_q;
  logic spd_q;
  logic cond_q;
  logic [2:0] mth_q;
  logic start_q;
  logic errclr_q;
  hps_pkg::hps_state_t st_q;
  logic [31:0] remain_q;
  logic done_q;
  logic lim_q;
  logic fwd_err_q;
  logic rev_err_q;
  logic nozero_q;
  logic [31:0] home_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic shift_neg;
  logic use_shift;
  logic hit_lim;
  logic cond_act;
  logic zp;
  logic [31:0] pos;
  logic [31:0] zlat;
  logic stepping;
  logic wr_stb;
  logic rd_stb;
  logic mapped;

  assign shift_neg = shift_q[31];
  always_comb begin
    unique case (hps_pkg::hps_method_t'(mth_q))
      hps_pkg::HPS_M_DOG, hps_pkg::HPS_M_COUNT,
      hps_pkg::HPS_M_CRADLE, hps_pkg::HPS_M_LIMSW:
        use_shift = 1'b1; // see R5
      default:
        use_shift = 1'b0; // see R5
    endcase
  end
  // only the limit in the travel direction can be reached
  assign hit_lim = (st_q == hps_pkg::HPS_SHIFT) &&
    ((!shift_neg && forward_limit_switch_i) ||
     (shift_neg && reverse_limit_switch_i)); // see R4

  // bus decode
  assign mapped = (wb_adr_i == hps_pkg::HPS_OFS_SHIFT) ||
    (wb_adr_i == hps_pkg::HPS_OFS_CTRL) ||
    (wb_adr_i == hps_pkg::HPS_OFS_STAT) ||
    (wb_adr_i == hps_pkg::HPS_OFS_HOME) ||
    (wb_adr_i == hps_pkg::HPS_OFS_POS);
  // write lands on the edge where the master sees ack, not before
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && mapped;
  assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end
  assign wb_ack_o = ack_q && mapped;
  assign wb_err_o = ack_q && !mapped;

  // shift distance, byte lanes honoured
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= hps_pkg::HPS_SHIFT_RST; // see R1
    end else if (wr_stb && wb_adr_i == hps_pkg::HPS_OFS_SHIFT) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          shift_q[8*i +: 8] <= wb_dat_i[8*i +: 8]; // see R1
        end
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      spd_q <= hps_pkg::HPS_SPD_RST; // see R2
      cond_q <= hps_pkg::HPS_COND_RST; // see R9
      mth_q <= 3'h0;
    end else if (wr_stb && wb_adr_i == hps_pkg::HPS_OFS_CTRL
                 && wb_sel_i[0]) begin
      spd_q <= wb_dat_i[hps_pkg::HPS_CTRL_SPD]; // see R2
      cond_q <= wb_dat_i[hps_pkg::HPS_CTRL_COND]; // see R9
      mth_q <= wb_dat_i[hps_pkg::HPS_CTRL_MTH_LSB +:
                        hps_pkg::HPS_CTRL_MTH_W];
    end
  end
  // self-clearing command strobes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
      errclr_q <= 1'b0;
    end else begin
      start_q <= wr_stb && wb_adr_i == hps_pkg::HPS_OFS_CTRL &&
        wb_sel_i[0] && wb_dat_i[hps_pkg::HPS_CTRL_START];
      errclr_q <= wr_stb && wb_adr_i == hps_pkg::HPS_OFS_CTRL &&
        wb_sel_i[0] && wb_dat_i[hps_pkg::HPS_CTRL_ERRCLR];
    end
  end

  // sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= hps_pkg::HPS_IDLE;
    end else begin
      unique case (st_q)
        hps_pkg::HPS_IDLE:
          if (start_q && !lim_q) begin
            st_q <= hps_pkg::HPS_SEEK;
          end
        hps_pkg::HPS_SEEK:
          if (zero_point_i && zp) begin
            st_q <= (use_shift && shift_q != '0) ?
              hps_pkg::HPS_SHIFT : hps_pkg::HPS_FIN; // see R3
          end
        hps_pkg::HPS_SHIFT:
          if (hit_lim) begin
            st_q <= hps_pkg::HPS_IDLE; // see R4
          end else if (stepping && remain_q == 32'h0000_0001) begin
            st_q <= hps_pkg::HPS_FIN; // see R3
          end
        hps_pkg::HPS_FIN:
          st_q <= hps_pkg::HPS_IDLE;
      endcase
    end
  end
  // zero point seen without zero-pass flag sets the no-zero status; the seek goes on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nozero_q <= 1'b0;
    end else if (st_q == hps_pkg::HPS_SEEK && zero_point_i && !zp) begin
      nozero_q <= 1'b1; // see R8
    end else if (start_q) begin
      nozero_q <= 1'b0;
    end
  end

  // remaining distance as magnitude
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remain_q <= '0;
    end else if (st_q == hps_pkg::HPS_SEEK && zero_point_i) begin
      remain_q <= shift_neg ? 32'(-shift_q) : shift_q; // see R13
    end else if (stepping) begin
      remain_q <= remain_q - 32'h0000_0001; // see R3
    end
  end
  assign stepping = (st_q == hps_pkg::HPS_SHIFT) && step_done_i && !hit_lim;

  // major error set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lim_q <= 1'b0;
      fwd_err_q <= 1'b0;
      rev_err_q <= 1'b0;
    end else if (hit_lim) begin
      lim_q <= 1'b1; // see R4
      fwd_err_q <= fwd_err_q | !shift_neg;
      rev_err_q <= rev_err_q | shift_neg;
    end else if (errclr_q) begin
      lim_q <= 1'b0;
      fwd_err_q <= 1'b0;
      rev_err_q <= 1'b0;
    end
  end

  // home and status only at the end of shift, not at zero point
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_q <= '0;
      done_q <= 1'b0;
    end else if (st_q == hps_pkg::HPS_FIN) begin
      home_q <= use_shift ? pos : zlat; // see R6
      done_q <= 1'b1; // see R6
    end else if (start_q) begin
      done_q <= 1'b0;
    end
  end

  hps_pos_cnt #(
    .W(32)
  ) u_pos (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .step_i(step_done_i && move_o),
    .dir_up_i(dir_up_o),
    .latch_i(st_q == hps_pkg::HPS_SEEK && zero_point_i),
    .pos_o(pos),
    .latched_o(zlat)
  );

  hps_zpass u_zp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_cfg_i(cond_q),
    .amp_power_i(amp_power_i),
    .ref_pass_i(ref_pass_i),
    .cond_act_o(cond_act),
    .zero_pass_flag_o(zp)
  );

  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= '0;
    end else if (rd_stb) begin
      unique case (wb_adr_i)
        hps_pkg::HPS_OFS_SHIFT: rdat_q <= shift_q;
        hps_pkg::HPS_OFS_CTRL:
          rdat_q <= {25'h0, mth_q, 2'b00, cond_q, spd_q};
        hps_pkg::HPS_OFS_STAT:
          rdat_q <= {24'h0, rev_err_q, fwd_err_q, cond_act, nozero_q,
                     zp, lim_q, done_q, st_q != hps_pkg::HPS_IDLE};
        hps_pkg::HPS_OFS_HOME: rdat_q <= home_q;
        hps_pkg::HPS_OFS_POS: rdat_q <= pos;
        default: rdat_q <= '0;
      endcase
    end
  end
  assign wb_dat_o = rdat_q;

  // motion command; seek direction left to the drive
  assign move_o = (st_q == hps_pkg::HPS_SHIFT);
  assign dir_up_o = !shift_neg; // see R13
  assign creep_o = spd_q; // see R2
  assign home_done_o = done_q;
  assign major_err_o = lim_q;
  assign zero_pass_flag_o = zp;
endmodule

// ==== bench/hps_axis_sva.sv ====
`timescale 1ns/10ps
module hps_axis_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic amp_power_i,
  input wire logic forward_limit_switch_i,
  input wire logic reverse_limit_switch_i,
  input wire logic move_o,
  input wire logic dir_up_o,
  input wire logic creep_o,
  input wire logic home_done_o,
  input wire logic major_err_o,
  input wire logic zero_pass_flag_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  bus_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
    !wb_err_o |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  fwd_limit_a: assert property (
    move_o && dir_up_o && forward_limit_switch_i |=> major_err_o && !move_o)
    else $error("forward limit not flagged");
  rev_limit_a: assert property (
    move_o && !dir_up_o && reverse_limit_switch_i |=> major_err_o && !move_o)
    else $error("reverse limit not flagged");
  done_late_a: assert property (move_o |-> !home_done_o)
    else $error("done during shift");
  done_after_a: assert property (
    $fell(move_o) && !major_err_o |-> ##[0:1] home_done_o)
    else $error("shift end without done");
  flag_needed_a: assert property ($rose(move_o) |-> zero_pass_flag_o)
    else $error("motion without zero pass");
  dir_hold_a: assert property (
    move_o && $past(move_o) |-> $stable(dir_up_o)) else $error("dir moved");
  speed_hold_a: assert property (
    move_o && $past(move_o) |-> $stable(creep_o)) else $error("speed moved");
  power_off_a: assert property (!amp_power_i |=> !zero_pass_flag_o)
    else $error("flag kept without power");
  cover property ($fell(move_o) ##1 home_done_o);
  cover property ($rose(major_err_o));
  cover property ($rose(zero_pass_flag_o));
endmodule
bind hps_axis hps_axis_sva u_sva (.*);

// ==== bench/hps_drive_model.sv ====
`timescale 1ns/10ps
module hps_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic move_i,
  input wire logic dir_up_i,
  input wire logic [31:0] fwd_lim_i,
  input wire logic [31:0] rev_lim_i,
  output logic step_done_o,
  output logic fls_o,
  output logic rls_o
);
  logic [31:0] pos_q;
  // one unit every other cycle, so steps are never back to back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_done_o <= 1'b0;
      pos_q <= 32'h0;
    end else begin
      step_done_o <= move_i & ~step_done_o;
      if (step_done_o) begin
        pos_q <= dir_up_i ? pos_q + 32'h1 : pos_q - 32'h1;
      end
    end
  end
  // switches stay on while the axis sits past them
  assign fls_o = $signed(pos_q) >= $signed(fwd_lim_i);
  assign rls_o = $signed(pos_q) <= $signed(rev_lim_i);
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic zero_point_i = 1'b0;
  logic ref_pass_i = 1'b0;
  logic amp_power_i = 1'b0;
  logic [31:0] wb_dat_o, rd, hexp, fwd = 32'h3e8, rev = 32'hffff_fc18;
  logic wb_ack_o, wb_err_o, forward_limit_switch_i, reverse_limit_switch_i;
  logic step_done_i, move_o, dir_up_o, creep_o, home_done_o, major_err_o;
  logic zero_pass_flag_o, er, dseen;
  int n_errors = 0;
  int checks = 0;
  int ticks = 0;
  hps_axis dut (.*);
  hps_drive_model drv (.clk_i(clk_i), .rst_i(rst_i), .move_i(move_o),
    .dir_up_i(dir_up_o), .fwd_lim_i(fwd), .rev_lim_i(rev),
    .step_done_o(step_done_i), .fls_o(forward_limit_switch_i),
    .rls_o(reverse_limit_switch_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rst_seq(input logic c, input logic p);
    rst_i <= 1'b1;
    amp_power_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    if (c) bus(8'h04, 1'b1, 32'h2);
    @(posedge clk_i);
    amp_power_i <= 1'b1;
    @(posedge clk_i);
    ref_pass_i <= p;
    @(posedge clk_i);
    ref_pass_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic run(input logic [2:0] m, input logic s, input logic [31:0] sh);
    bus(8'h00, 1'b1, sh); // distances kept in signed 32 bits
    bus(8'h04, 1'b1, {25'h0, m, 3'b010, s});
    dseen = 1'bx;
    repeat (2) @(posedge clk_i);
    zero_point_i <= 1'b1;
    @(posedge clk_i);
    zero_point_i <= 1'b0;
    for (int i = 0; i < 300 && home_done_o !== 1'b1 &&
         major_err_o !== 1'b1; i++) begin
      @(posedge clk_i);
      if (move_o === 1'b1) dseen = dir_up_o;
    end
    bus(8'h0c, 1'b0, 32'h0);
  endtask
  initial begin
    rst_seq(1'b0, 1'b0);
    bus(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h0);
    chk(creep_o, 1'b0);
    chk(zero_pass_flag_o, 1'b0);
    bus(8'h14, 1'b0, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    for (int i = 0; i < 2; i++) begin
      hexp = i ? 32'h8000_0000 : 32'h7fff_ffff;
      bus(8'h00, 1'b1, hexp);
      bus(8'h00, 1'b0, 32'h0);
      chk(rd, hexp);
    end
    wb_sel_i <= 4'h1;
    bus(8'h00, 1'b1, 32'h0000_00aa);
    wb_sel_i <= 4'hf;
    bus(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h8000_00aa);
    run(3'h0, 1'b0, 32'h5);
    chk(home_done_o, 1'b0);
    bus(8'h08, 1'b0, 32'h0);
    chk(rd[4:3], 2'b10);
    ref_pass_i <= 1'b1;
    @(posedge clk_i);
    ref_pass_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk(zero_pass_flag_o, 1'b1);
    hexp = 32'h0;
    for (int m = 0; m < 6; m++) begin
      run(m[2:0], 1'b1, 32'hffff_fffe);
      // data-set and stopper methods leave the shift unused
      if (m != 2 && m != 4) hexp = hexp - 32'h2;
      chk(rd, hexp);
      chk(home_done_o, 1'b1);
      chk(creep_o, 1'b1);
      if (m != 2 && m != 4) chk(dseen, 1'b0);
    end
    run(3'h0, 1'b0, 32'h5);
    chk(rd, hexp + 32'h5);
    bus(8'h10, 1'b0, 32'h0);
    chk(rd, hexp + 32'h5);
    chk(dseen, 1'b1);
    fwd <= hexp + 32'h8;
    run(3'h0, 1'b0, 32'ha);
    chk({home_done_o, major_err_o}, 2'b01);
    bus(8'h08, 1'b0, 32'h0);
    chk(rd[7:6], 2'b01);
    bus(8'h04, 1'b1, 32'h8);
    repeat (2) @(posedge clk_i);
    chk(major_err_o, 1'b0);
    fwd <= 32'h3e8;
    rev <= 32'hffff_fffd;
    rst_seq(1'b0, 1'b1);
    run(3'h0, 1'b0, 32'hffff_fff6);
    chk({home_done_o, major_err_o}, 2'b01);
    bus(8'h08, 1'b0, 32'h0);
    chk(rd[7:6], 2'b10);
    // a finite axis, so the no-pass condition is safe
    rst_seq(1'b0, 1'b0);
    bus(8'h04, 1'b1, 32'h2);
    amp_power_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    amp_power_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(zero_pass_flag_o, 1'b0);
    rst_seq(1'b1, 1'b0);
    chk(zero_pass_flag_o, 1'b1);
    summarize();
  end
endmodule
